/* genlock_pkg.sv */
// Constants for the genlock status and control register bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
//
// Summary of operation
// - Reference locked is high only when field, vertical, horizontal and clock lock are all high, a masked term counting as high.
// - The sync-fail pin is always the inverse of reference locked.
// - Field locked, bit 4, is high once the output field is genlocked to the field sync input.
// - Without a field sync input, field locked copies vertical locked, bit 3.
// - Vertical locked, bit 3, is high once the output vertical is genlocked to vertical sync.
// - Horizontal locked, bit 2, is high once the output horizontal is genlocked to horizontal sync.
// - Clock locked, bit 1, is high only when both video and audio clocks are locked to their PLLs.
// - Reference present, bit 0, is high while a valid reference is applied; the reference-absent pin is its inverse.
// - Control bit 5 high hands genlock to the host bit; low leaves the genlock pin in charge.
// - The host genlock bit, control bit 0, is ignored while control bit 5 is low.
// - Control bits 4, 3 and 2 each drop the field, vertical or horizontal term from reference locked.
// - Control bit 1 high selects drift locking to a new reference, low selects crash locking.
// - Control bit 6 enables extended audio mode and resets to zero.
package genlock_pkg;

  localparam int ADR_W = 8;
  localparam int IDX_W = 6;

  // =====================================================================
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h15;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h16;
  localparam logic [IDX_W-1:0] IDX_RESERVED_BLOCK = 6'h17;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h21;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h22;

  // =====================================================================
  // Status word fields
  localparam int ST_REF_PRESENT = 0;
  localparam int ST_CLK_LOCK = 1;
  localparam int ST_H_LOCK = 2;
  localparam int ST_V_LOCK = 3;
  localparam int ST_F_LOCK = 4;
  localparam int ST_REF_LOCK = 5;
  localparam int ST_W = 6;

  // =====================================================================
  // Control word fields
  localparam int CT_HOST_GENLOCK = 0;
  localparam int CT_DRIFT = 1;
  localparam int CT_H_MASK = 2;
  localparam int CT_V_MASK = 3;
  localparam int CT_F_MASK = 4;
  localparam int CT_GENLOCK_FROM_HOST = 5;
  localparam int CT_EXT_AUDIO = 6;
  localparam int CT_W = 7;
  localparam logic [CT_W-1:0] CT_RESET = 7'h00;

  // =====================================================================
  // Interrupt events
  localparam int EV_REF_UP = 0;
  localparam int EV_REF_DOWN = 1;
  localparam int EV_LOCK_UP = 2;
  localparam int EV_LOCK_DOWN = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;

  // =====================================================================
  // Synchronised input bit positions
  localparam int IN_REF_VALID = 0;
  localparam int IN_FIELD_SYNC_IN_PRESENT = 1;
  localparam int IN_F_LOCK = 2;
  localparam int IN_V_LOCK = 3;
  localparam int IN_H_LOCK = 4;
  localparam int IN_VPLL_LOCK = 5;
  localparam int IN_APLL_LOCK = 6;
  localparam int IN_GENLOCK_PIN = 7;
  localparam int IN_W = 8;

endpackage

/* genlock_sync.sv */
// Two-flop synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level; no bus coherency is promised.
`timescale 1ns/10ps
module genlock_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // =====================================================================
  // First stage is read only by the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* genlock_regs.sv */
// Genlock status and control registers with a Wishbone slave port.
// Assumes lock and presence inputs arrive asynchronously from detectors.
`timescale 1ns/10ps
module genlock_regs
  import genlock_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Detector and pin inputs
  input wire logic ref_valid_in,
  input wire logic field_sync_present_in,
  input wire logic field_lock_in,
  input wire logic vert_lock_in,
  input wire logic horz_lock_in,
  input wire logic video_pll_lock_in,
  input wire logic audio_pll_lock_in,
  input wire logic genlock_pin_in,
  // Outputs
  output logic lock_lost,
  output logic ref_lost,
  output logic genlock_en,
  output logic drift_lock_en,
  output logic ext_audio_en,
  output logic irq
);

  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] in_s;
  logic [ST_W-1:0] status_d;
  logic [ST_W-1:0] status_q;
  logic [CT_W-1:0] control_q;
  logic [EV_W-1:0] irq_sts_q;
  logic [EV_W-1:0] irq_en_q;
  logic [EV_W-1:0] events;
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic field_term;
  logic ref_lock_d;
  logic [15:0] ctl_merged;
  logic [15:0] ien_merged;

  // Byte-lane merge of a write into a narrow register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  // =====================================================================
  // Input synchronisation
  assign raw_in = {genlock_pin_in, audio_pll_lock_in, video_pll_lock_in,
                   horz_lock_in, vert_lock_in, field_lock_in,
                   field_sync_present_in, ref_valid_in};

  genlock_sync #(.WIDTH(IN_W)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(in_s)
  );

  // =====================================================================
  // Status word
  always_comb begin
    status_d = '0;
    status_d[ST_REF_PRESENT] = in_s[IN_REF_VALID];
    status_d[ST_CLK_LOCK] = in_s[IN_VPLL_LOCK] & in_s[IN_APLL_LOCK];
    status_d[ST_H_LOCK] = in_s[IN_H_LOCK];
    status_d[ST_V_LOCK] = in_s[IN_V_LOCK];
    // Field term follows vertical when no field sync exists
    field_term = in_s[IN_FIELD_SYNC_IN_PRESENT] ? in_s[IN_F_LOCK]
                                        : in_s[IN_V_LOCK];
    status_d[ST_F_LOCK] = field_term;
    ref_lock_d = (field_term | control_q[CT_F_MASK]) &
                 (in_s[IN_V_LOCK] | control_q[CT_V_MASK]) &
                 (in_s[IN_H_LOCK] | control_q[CT_H_MASK]) &
                 status_d[ST_CLK_LOCK];
    status_d[ST_REF_LOCK] = ref_lock_d;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign lock_lost = ~status_q[ST_REF_LOCK];
  assign ref_lost = ~status_q[ST_REF_PRESENT];

  // =====================================================================
  // Bus decode
  assign idx = wb_adr_i[ADR_W-1:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // =====================================================================
  // Control register
  assign ctl_merged = lane_merge({9'h000, control_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control_q <= CT_RESET;
    end else if (wr && idx == IDX_CONTROL) begin
      // Upper bits are dropped; software keeps them zero
      control_q <= ctl_merged[CT_W-1:0];
    end
  end

  assign genlock_en = control_q[CT_GENLOCK_FROM_HOST] ?
                      control_q[CT_HOST_GENLOCK] :
                      in_s[IN_GENLOCK_PIN];
  assign drift_lock_en = control_q[CT_DRIFT];
  assign ext_audio_en = control_q[CT_EXT_AUDIO];

  // =====================================================================
  // Interrupts
  assign events[EV_REF_UP] = status_d[ST_REF_PRESENT] &
                             ~status_q[ST_REF_PRESENT];
  assign events[EV_REF_DOWN] = ~status_d[ST_REF_PRESENT] &
                               status_q[ST_REF_PRESENT];
  assign events[EV_LOCK_UP] = status_d[ST_REF_LOCK] &
                              ~status_q[ST_REF_LOCK];
  assign events[EV_LOCK_DOWN] = ~status_d[ST_REF_LOCK] &
                                status_q[ST_REF_LOCK];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_sts_q <= EV_RESET;
    end else if (wr && idx == IDX_IRQ_CLEAR && wb_sel_i[0]) begin
      // A new event wins over its clear
      irq_sts_q <= (irq_sts_q & ~wb_dat_i[EV_W-1:0]) | events;
    end else begin
      irq_sts_q <= irq_sts_q | events;
    end
  end

  assign ien_merged = lane_merge({12'h000, irq_en_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_en_q <= EV_RESET;
    end else if (wr && idx == IDX_IRQ_ENABLE) begin
      irq_en_q <= ien_merged[EV_W-1:0];
    end
  end

  assign irq = |(irq_sts_q & irq_en_q);

  // =====================================================================
  // Read path
  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      IDX_STATUS: rdata[ST_W-1:0] = status_q;
      IDX_CONTROL: rdata[CT_W-1:0] = control_q;
      IDX_IRQ_STATUS: rdata[EV_W-1:0] = irq_sts_q;
      IDX_IRQ_ENABLE: rdata[EV_W-1:0] = irq_en_q;
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= rdata;
    end
  end

  // =====================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ref_lock_and: assert property (
    status_q[ST_REF_LOCK] |-> status_q[ST_CLK_LOCK] &&
      (status_q[ST_F_LOCK] || $past(control_q[CT_F_MASK])) &&
      (status_q[ST_V_LOCK] || $past(control_q[CT_V_MASK])) &&
      (status_q[ST_H_LOCK] || $past(control_q[CT_H_MASK])))
    else $error("reference lock set with an unmasked term low");

  a_lock_lost_inv: assert property (
    lock_lost == !status_q[ST_REF_LOCK])
    else $error("sync fail pin not inverse of reference lock");

  a_field_lock_in: assert property (
    $past(field_sync_present_in, 3) |->
      status_q[ST_F_LOCK] == $past(field_lock_in, 3))
    else $error("field lock does not follow its input");

  a_field_no_sync: assert property (
    !$past(field_sync_present_in, 3) |->
      status_q[ST_F_LOCK] == status_q[ST_V_LOCK])
    else $error("field lock differs from vertical without field sync");

  a_vert_lock_in: assert property (
    status_q[ST_V_LOCK] == $past(vert_lock_in, 3))
    else $error("vertical lock does not follow its input");

  a_horz_lock_in: assert property (
    status_q[ST_H_LOCK] == $past(horz_lock_in, 3))
    else $error("horizontal lock does not follow its input");

  a_clock_lock_and: assert property (
    status_q[ST_CLK_LOCK] ==
      ($past(video_pll_lock_in, 3) && $past(audio_pll_lock_in, 3)))
    else $error("clock lock not the and of both PLL locks");

  a_ref_present_pin: assert property (
    status_q[ST_REF_PRESENT] == $past(ref_valid_in, 3) &&
      ref_lost == !status_q[ST_REF_PRESENT])
    else $error("reference present or its pin wrong");

  a_host_genlock_sel: assert property (
    control_q[CT_GENLOCK_FROM_HOST] |->
      genlock_en == control_q[CT_HOST_GENLOCK])
    else $error("host genlock not applied");

  a_pin_genlock_sel: assert property (
    !control_q[CT_GENLOCK_FROM_HOST] |->
      genlock_en == $past(genlock_pin_in, 2))
    else $error("genlock pin not in charge");

  a_mask_all_lock: assert property (
    (control_q[CT_F_MASK] && control_q[CT_V_MASK] &&
     control_q[CT_H_MASK] && $stable(control_q) && in_s[IN_VPLL_LOCK] &&
     in_s[IN_APLL_LOCK]) |=> status_q[ST_REF_LOCK])
    else $error("masked terms still block reference lock");

  a_drift_write: assert property (
    (wr && idx == IDX_CONTROL && wb_sel_i[0]) |=>
      drift_lock_en == $past(wb_dat_i[CT_DRIFT]))
    else $error("drift select not taken from write");

  a_audio_write: assert property (
    (wr && idx == IDX_CONTROL && wb_sel_i[0]) |=>
      ext_audio_en == $past(wb_dat_i[CT_EXT_AUDIO]))
    else $error("extended audio enable not taken from write");

  a_status_read: assert property (
    (rd && idx == IDX_STATUS) |=> wb_ack_o &&
      wb_dat_o[31:ST_W] == '0 && wb_dat_o[ST_W-1:0] == $past(status_q))
    else $error("status read wrong");

  a_control_hold: assert property (
    !(wr && idx == IDX_CONTROL) |=> $stable(control_q))
    else $error("control changed without a write");

  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_control_reset: assert property (
    $fell(rst) |-> control_q == CT_RESET && status_q == '0 && !wb_ack_o)
    else $error("control or status not at reset value");

  a_irq_set_wins: assert property (
    (wr && idx == IDX_IRQ_CLEAR && wb_sel_i[0]) |=>
      (irq_sts_q & $past(events)) == $past(events))
    else $error("interrupt event lost to a clear");

  a_irq_clear_bit: assert property (
    (wr && idx == IDX_IRQ_CLEAR && wb_sel_i[0] &&
     wb_dat_i[EV_LOCK_UP] && !events[EV_LOCK_UP]) |=>
      !irq_sts_q[EV_LOCK_UP])
    else $error("lock up interrupt not cleared");

  c_lock_gained: cover property (
    !status_q[ST_REF_LOCK] ##1 status_q[ST_REF_LOCK]);
  c_host_genlock: cover property (
    control_q[CT_GENLOCK_FROM_HOST] && genlock_en);
  c_irq_raised: cover property (!irq ##1 irq);
  c_field_absent: cover property (
    !in_s[IN_FIELD_SYNC_IN_PRESENT] && status_q[ST_F_LOCK]);

endmodule

/* genlock_ref_model.sv */
// Model of the incoming reference and its lock detectors.
// Assumes the bench picks a scene vector; bits feed the detector outputs.
`timescale 1ns/10ps
module genlock_ref_model (
  input wire logic [7:0] scene,
  output logic ref_valid_in,
  output logic field_sync_present_in,
  output logic field_lock_in,
  output logic vert_lock_in,
  output logic horz_lock_in,
  output logic video_pll_lock_in,
  output logic audio_pll_lock_in,
  output logic genlock_pin_in
);
  // ===================================================================
  // Detectors
  always_comb begin
    ref_valid_in = scene[0];
    field_sync_present_in = scene[0] & scene[1];
    vert_lock_in = scene[0] & scene[3];
    horz_lock_in = scene[0] & scene[4];
    // Field detector output is junk without field sync
    field_lock_in = field_sync_present_in ? scene[2] : ~vert_lock_in;
    video_pll_lock_in = scene[5];
    audio_pll_lock_in = scene[6];
    genlock_pin_in = scene[7];
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the genlock register bank.
// Assumes the bank acks each Wishbone request one cycle after taking it.
`timescale 1ns/10ps
module tb_top;
  import genlock_pkg::*;
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CT = {IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_RS = {IDX_RESERVED_BLOCK, 2'b00};
  localparam logic [7:0] A_IS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] A_IC = {IDX_IRQ_CLEAR, 2'b00};
  localparam logic [7:0] A_IE = {IDX_IRQ_ENABLE, 2'b00};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, lock_lost, ref_lost, genlock_en, drift_lock_en;
  logic ext_audio_en, irq, ref_valid_in, field_sync_present_in;
  logic field_lock_in, vert_lock_in, horz_lock_in, video_pll_lock_in;
  logic audio_pll_lock_in, genlock_pin_in;
  logic [7:0] scene = 8'h00;
  logic [31:0] seed = 32'h0de5;
  logic [6:0] ctl;
  logic [31:0] exp_q[$];
  int failures = 0, tests_run = 0;

  always #10 clk_sys = ~clk_sys;

  genlock_ref_model i_genlock_ref_model (
    .scene(scene),
    .ref_valid_in(ref_valid_in),
    .field_sync_present_in(field_sync_present_in),
    .field_lock_in(field_lock_in),
    .vert_lock_in(vert_lock_in),
    .horz_lock_in(horz_lock_in),
    .video_pll_lock_in(video_pll_lock_in),
    .audio_pll_lock_in(audio_pll_lock_in),
    .genlock_pin_in(genlock_pin_in)
  );

  genlock_regs i_genlock_regs (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .ref_valid_in(ref_valid_in),
    .field_sync_present_in(field_sync_present_in),
    .field_lock_in(field_lock_in),
    .vert_lock_in(vert_lock_in),
    .horz_lock_in(horz_lock_in),
    .video_pll_lock_in(video_pll_lock_in),
    .audio_pll_lock_in(audio_pll_lock_in),
    .genlock_pin_in(genlock_pin_in),
    .lock_lost(lock_lost),
    .ref_lost(ref_lost),
    .genlock_en(genlock_en),
    .drift_lock_en(drift_lock_en),
    .ext_audio_en(ext_audio_en),
    .irq(irq)
  );

  // ===================================================================
  // Checking
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [31:0] exp_status(input logic [6:0] c);
    logic f, k, l;
    f = field_sync_present_in ? field_lock_in : vert_lock_in;
    k = video_pll_lock_in & audio_pll_lock_in;
    l = (f | c[4]) & (vert_lock_in | c[3]) & (horz_lock_in | c[2]) & k;
    return {26'h0, l, f, vert_lock_in, horz_lock_in, k, ref_valid_in};
  endfunction

  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_pin(input logic got, input logic exp, string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: pin %s", $time, what);
    end
  endtask

  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask

  // Read results taken at the ack edge, oldest note first
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check_rd(wb_dat_o, exp_q.size() ? exp_q.pop_front() : 32'hx);
  end

  task automatic check_outs(input logic [6:0] c);
    logic [31:0] es;
    es = exp_status(c);
    check_pin(lock_lost, !es[5], "lock_lost");
    check_pin(ref_lost, !es[0], "ref_lost");
    check_pin(genlock_en, c[5] ? c[0] : genlock_pin_in, "genlock");
    check_pin(drift_lock_en, c[1], "drift");
    check_pin(ext_audio_en, c[6], "audio");
  endtask

  // ===================================================================
  // Wishbone master
  task automatic wb_cycle(input logic we, input logic [ADR_W-1:0] adr,
                          input logic [31:0] dat);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= dat;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (wb_ack_o === 1'b1)
        break;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20) begin
      failures++;
      $display("wrong value at %0t: no ack", $time);
      summarize();
    end
  endtask

  task automatic wb_read(input logic [ADR_W-1:0] adr, input logic [31:0] e);
    exp_q.push_back(e);
    wb_cycle(1'b0, adr, 32'h0);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask

  // ===================================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    wb_read(A_CT, 32'h0);
    wb_read(A_ST, 32'h0);
    settle();
    check_outs(7'h00);
    check_pin(irq, 1'b0, "irq");
    $display("test reset done");
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      ctl = seed[6:0];
      scene <= (i < 2) ? 8'hff : seed[15:8];
      wb_cycle(1'b1, A_CT, {25'h0, ctl});
      settle();
      wb_read(A_CT, {25'h0, ctl});
      wb_read(A_ST, exp_status(ctl));
      check_outs(ctl);
    end
    $display("test lock and control done");
    wb_cycle(1'b1, A_ST, 32'hffff);
    wb_read(A_ST, exp_status(ctl));
    wb_cycle(1'b1, A_RS, 32'hffff);
    wb_read(A_RS, 32'h0);
    wb_read(8'hfc, 32'h0);
    $display("test read-only places done");
    scene <= 8'h00;
    settle();
    wb_cycle(1'b1, A_IE, 32'h0);
    wb_cycle(1'b1, A_IC, 32'hf);
    wb_read(A_IS, 32'h0);
    scene <= 8'h7f;
    settle();
    wb_read(A_IS, 32'h5);
    check_pin(irq, 1'b0, "irq masked");
    wb_cycle(1'b1, A_IE, 32'h4);
    settle();
    check_pin(irq, 1'b1, "irq raised");
    wb_cycle(1'b1, A_IC, 32'h4);
    settle();
    check_pin(irq, 1'b0, "irq cleared");
    wb_read(A_IS, 32'h1);
    wb_read(A_IE, 32'h4);
    wb_read(A_IC, 32'h0);
    $display("test interrupts done");
    // Let the monitor take the last read before the verdict
    repeat (2) @(posedge clk_sys);
    summarize();
  end
endmodule
